// File: logic/kmc_pkg.sv
// Package: shared constants of the keyboard and mouse controller.
// Assumes: all users reference names as kmc_pkg::name.
package kmc_pkg;
  // ----------------------------------------------------------------
  // Host port map
  // ----------------------------------------------------------------
  localparam logic [7:0] DATA_PORT_ADDR   = 8'h60;
  localparam logic [7:0] STATUS_PORT_ADDR = 8'h64;
  // ----------------------------------------------------------------
  // Host commands
  // ----------------------------------------------------------------
  localparam logic [7:0] CMD_READ_CCB     = 8'h20;
  localparam logic [7:0] CMD_WRITE_CCB    = 8'h60;
  // ----------------------------------------------------------------
  // Status bit positions
  // ----------------------------------------------------------------
  localparam int ST_PARITY   = 7;
  localparam int ST_TIMEOUT  = 6;
  localparam int ST_MOUSE_OB = 5;
  localparam int ST_NOINHIB  = 4;
  localparam int ST_CMD_DATA = 3;
  localparam int ST_SYSFLAG  = 2;
  localparam int ST_IBF      = 1;
  localparam int ST_OBF      = 0;
  // ----------------------------------------------------------------
  // Command byte bit positions and reset value
  // ----------------------------------------------------------------
  localparam int CB_TRANSLATE  = 6;
  localparam int CB_MOUSE_DIS  = 5;
  localparam int CB_KBD_DIS    = 4;
  localparam int CB_SYSFLAG    = 2;
  localparam int CB_MOUSE_IE   = 1;
  localparam int CB_KBD_IE     = 0;
  localparam logic [7:0] CCB_RESET    = 8'h47;
  localparam logic [7:0] CCB_WR_MASK  = 8'h77;
  localparam logic [7:0] DATA_RESET   = 8'h00;
  localparam logic [7:0] STATUS_RESET = 8'h00;
  // ----------------------------------------------------------------
  // Link timing
  // ----------------------------------------------------------------
  localparam int LINK_BITS       = 11;
  localparam int TIMEOUT_US      = 2;
  localparam int MCLK_MHZ        = 100;
  localparam int TIMEOUT_CYCLES  = TIMEOUT_US * MCLK_MHZ;
endpackage

// File: logic/kmc_ps2_rx.sv
// Receiver for one serial channel, running on the link clock.
// Assumes: link clock edges only during a frame; the peripheral
// launches data on the link clock's rising edge.
module kmc_ps2_rx (
  input  wire logic       link_clk,
  input  wire logic       link_rst_n,
  input  wire logic       ps2_data_i,
  output logic            byte_tgl,
  output logic [7:0]      byte_data,
  output logic            byte_perr
);
  logic [3:0]  bit_cnt_r;
  logic [9:0]  shift_r;

  // Data already belongs to this clock; extra stages would push the
  // last bits past the final edge, since the clock stops after a frame.
  // Sampling on the falling edge, as the peripheral shifts on rising
  always_ff @(negedge link_clk) begin
    if (!link_rst_n) begin
      bit_cnt_r <= 4'h0;
      shift_r   <= 10'h000;
      byte_tgl  <= 1'b0;
      byte_data <= 8'h00;
      byte_perr <= 1'b0;
    end else if (bit_cnt_r == 4'h0) begin
      if (!ps2_data_i) bit_cnt_r <= 4'h1;
    end else if (bit_cnt_r == 4'(kmc_pkg::LINK_BITS - 1)) begin
      bit_cnt_r <= 4'h0;
      if (ps2_data_i) begin
        byte_data <= shift_r[8:1];
        byte_perr <= ~(^shift_r[9:1]); // R01
        byte_tgl  <= ~byte_tgl;
      end
    end else begin
      shift_r   <= {ps2_data_i, shift_r[9:1]};
      bit_cnt_r <= bit_cnt_r + 4'h1;
    end
  end
endmodule

// File: logic/kmc_xlate.sv
// Scan-code translator from set 2 codes to the standard PC set.
// Assumes: a combinational table; unknown codes pass unchanged.
module kmc_xlate (
  input  wire logic [7:0] code_in,
  input  wire logic       break_pend,
  output logic [7:0]      code_out
);
  logic [7:0] base;
  always_comb begin
    base = code_in;
    case (code_in)
      8'h76: base = 8'h01;
      8'h16: base = 8'h02;
      8'h1E: base = 8'h03;
      8'h26: base = 8'h04;
      8'h25: base = 8'h05;
      8'h2E: base = 8'h06;
      8'h36: base = 8'h07;
      8'h3D: base = 8'h08;
      8'h3E: base = 8'h09;
      8'h46: base = 8'h0A;
      8'h45: base = 8'h0B;
      8'h66: base = 8'h0E;
      8'h0D: base = 8'h0F;
      8'h15: base = 8'h10;
      8'h1D: base = 8'h11;
      8'h24: base = 8'h12;
      8'h2D: base = 8'h13;
      8'h5A: base = 8'h1C;
      8'h14: base = 8'h1D;
      8'h1C: base = 8'h1E;
      8'h1B: base = 8'h1F;
      8'h12: base = 8'h2A;
      8'h29: base = 8'h39;
      default: base = code_in;
    endcase
    code_out = break_pend ? (base | 8'h80) : base;
  end
endmodule

// File: logic/kmc_ctrl.sv
// Top of the keyboard and mouse controller host port.
// Assumes: host strobes are one mclk cycle and synchronous to mclk;
// each link has its own clock, edges only while a frame is sent.

// What this block does
// R01 - Receive serial bytes, check parity, buffer
// R02 - Interrupt on buffer load, per enable bit
// R03 - Read-only status port, reads 14h after reset unless keyboard inhibited
// R04 - Status bit 5 flags mouse byte
// R05 - Status bit 4 is inverted inhibit
// R06 - Status bit 2 mirrors command byte flag
// R07 - Status bit 1 shows host byte pending
// R08 - Status bit 0 shows output byte pending
// R09 - Commands 20h and 60h access command byte
// R10 - Command bit 6 enables code translation
// R11 - Command bit 5 overrides mouse inhibit
// R12 - Command bit 4 overrides keyboard inhibit
// R13 - Command bit 2 holds system flag
// R14 - Command bits 1,0 enable mouse/keyboard interrupts
// R15 - Data port at 60h, zero at reset
// R16 - Data port carries scan codes and replies
// R17 - Data read clears full and mouse-full
// R18 - Host write sets input full, records kind
module kmc_ctrl (
  input  wire logic       mclk,
  input  wire logic       rst_n,
  input  wire logic       kbd_clk,
  input  wire logic       kbd_rst_n,
  input  wire logic       kbd_data_i,
  input  wire logic       mouse_clk,
  input  wire logic       mouse_rst_n,
  input  wire logic       mouse_data_i,
  input  wire logic [7:0] host_addr,
  input  wire logic [7:0] host_wdata,
  input  wire logic       host_wr,
  input  wire logic       host_rd,
  input  wire logic       kbd_inhibit_sw,
  input  wire logic       mouse_inhibit_sw,
  output logic [7:0]      host_rdata,
  output logic            kbd_irq_line,
  output logic            mouse_irq_line,
  output logic            kbd_inhibit_o,
  output logic            mouse_inhibit_o
);
  // ----------------------------------------------------------------
  // Controller command state
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    KMC_IDLE    = 2'b00,
    KMC_EXEC    = 2'b01,
    KMC_WAIT_WR = 2'b10
  } kmc_cmd_e;

  kmc_cmd_e   cmd_state_r;
  logic [7:0] ctrl_command_byte_r;
  logic [7:0] inbuf_r;
  logic       inbuf_full_r;
  logic       inbuf_is_cmd_r;
  logic [7:0] outbuf_r;
  logic       outbuf_full_r;
  logic       mouse_outbuf_full_r;
  logic       perr_r;
  logic       timeout_r;
  logic       reply_pend_r;
  logic [7:0] reply_r;
  logic       break_pend_r;

  // ----------------------------------------------------------------
  // Link receivers and crossings
  // ----------------------------------------------------------------
  logic       kbd_tgl;
  logic [7:0] kbd_byte;
  logic       kbd_perr;
  logic       mouse_tgl;
  logic [7:0] mouse_byte;
  logic       mouse_perr;

  kmc_ps2_rx u_kbd_rx (
    .link_clk   (kbd_clk),
    .link_rst_n (kbd_rst_n),
    .ps2_data_i (kbd_data_i),
    .byte_tgl   (kbd_tgl),
    .byte_data  (kbd_byte),
    .byte_perr  (kbd_perr)
  );

  kmc_ps2_rx u_mouse_rx (
    .link_clk   (mouse_clk),
    .link_rst_n (mouse_rst_n),
    .ps2_data_i (mouse_data_i),
    .byte_tgl   (mouse_tgl),
    .byte_data  (mouse_byte),
    .byte_perr  (mouse_perr)
  );

  // Toggle crossing; the byte word is stable long after each toggle,
  // since a frame lasts many mclk cycles.
  logic [2:0] kbd_tgl_sync_r;
  logic [2:0] mouse_tgl_sync_r;
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      kbd_tgl_sync_r   <= 3'h0;
      mouse_tgl_sync_r <= 3'h0;
    end else begin
      kbd_tgl_sync_r   <= {kbd_tgl_sync_r[1:0], kbd_tgl};
      mouse_tgl_sync_r <= {mouse_tgl_sync_r[1:0], mouse_tgl};
    end
  end
  logic kbd_evt;
  logic mouse_evt;
  assign kbd_evt   = kbd_tgl_sync_r[2] ^ kbd_tgl_sync_r[1];
  assign mouse_evt = mouse_tgl_sync_r[2] ^ mouse_tgl_sync_r[1];

  // Pending link bytes wait here while the output buffer is full
  logic       kbd_pend_r;
  logic [7:0] kbd_hold_r;
  logic       kbd_hold_perr_r;
  logic       mouse_pend_r;
  logic [7:0] mouse_hold_r;
  logic       mouse_hold_perr_r;

  // ----------------------------------------------------------------
  // Inhibit and translation
  // ----------------------------------------------------------------
  // Inhibit requests come from pins: two stages before any use
  logic [1:0] kbd_inh_sync_r;
  logic [1:0] mouse_inh_sync_r;
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      kbd_inh_sync_r   <= 2'h0;
      mouse_inh_sync_r <= 2'h0;
    end else begin
      kbd_inh_sync_r   <= {kbd_inh_sync_r[0], kbd_inhibit_sw};
      mouse_inh_sync_r <= {mouse_inh_sync_r[0], mouse_inhibit_sw};
    end
  end

  logic kbd_inhibited;
  logic mouse_inhibited;
  assign kbd_inhibited =
    kbd_inh_sync_r[1] & ~ctrl_command_byte_r[kmc_pkg::CB_KBD_DIS]; // R12
  assign mouse_inhibited =
    mouse_inh_sync_r[1] &
    ~ctrl_command_byte_r[kmc_pkg::CB_MOUSE_DIS]; // R11

  logic [7:0] kbd_xlated;
  kmc_xlate u_xlate (
    .code_in    (kbd_hold_r),
    .break_pend (break_pend_r),
    .code_out   (kbd_xlated)
  );
  logic xlate_on;
  assign xlate_on = ctrl_command_byte_r[kmc_pkg::CB_TRANSLATE]; // R10
  logic kbd_is_break;
  assign kbd_is_break = xlate_on & (kbd_hold_r == 8'hF0);

  // ----------------------------------------------------------------
  // Host access decode
  // ----------------------------------------------------------------
  logic wr_data;
  logic wr_cmd;
  logic rd_data;
  assign wr_data = host_wr & (host_addr == kmc_pkg::DATA_PORT_ADDR);
  assign wr_cmd  = host_wr & (host_addr == kmc_pkg::STATUS_PORT_ADDR);
  assign rd_data = host_rd & (host_addr == kmc_pkg::DATA_PORT_ADDR);

  // Load priority: command reply, then keyboard, then mouse
  logic load_reply;
  logic load_kbd;
  logic load_mouse;
  logic ob_free;
  assign ob_free    = ~outbuf_full_r | rd_data;
  assign load_reply = ob_free & reply_pend_r;
  assign load_kbd   = ob_free & ~reply_pend_r & kbd_pend_r &
                      ~kbd_is_break;
  assign load_mouse = ob_free & ~reply_pend_r & ~kbd_pend_r &
                      mouse_pend_r;

  // ----------------------------------------------------------------
  // Link byte holding
  // ----------------------------------------------------------------
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      kbd_pend_r      <= 1'b0;
      kbd_hold_r      <= 8'h00;
      kbd_hold_perr_r <= 1'b0;
      break_pend_r    <= 1'b0;
    end else begin
      if (kbd_evt && !kbd_inhibited) begin // R01
        kbd_pend_r      <= 1'b1;
        kbd_hold_r      <= kbd_byte;
        kbd_hold_perr_r <= kbd_perr;
      end else if (load_kbd || (kbd_pend_r && kbd_is_break)) begin
        kbd_pend_r <= 1'b0;
      end
      // Break prefix is folded into the next code as its top bit
      if (kbd_pend_r && kbd_is_break && !kbd_evt) begin
        break_pend_r <= 1'b1;
      end else if (load_kbd) begin
        break_pend_r <= 1'b0;
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      mouse_pend_r      <= 1'b0;
      mouse_hold_r      <= 8'h00;
      mouse_hold_perr_r <= 1'b0;
    end else if (mouse_evt && !mouse_inhibited) begin // R01
      mouse_pend_r      <= 1'b1;
      mouse_hold_r      <= mouse_byte;
      mouse_hold_perr_r <= mouse_perr;
    end else if (load_mouse) begin
      mouse_pend_r <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Input buffer and command handling
  // ----------------------------------------------------------------
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      inbuf_r        <= 8'h00;
      inbuf_full_r   <= 1'b0;
      inbuf_is_cmd_r <= 1'b0;
    end else if (wr_data || wr_cmd) begin
      // Set wins over the consume in the same cycle
      inbuf_r        <= host_wdata;
      inbuf_full_r   <= 1'b1; // R07 R18
      inbuf_is_cmd_r <= wr_cmd; // R18
    end else if (inbuf_full_r && cmd_state_r != KMC_EXEC) begin
      inbuf_full_r <= 1'b0; // R07
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      cmd_state_r         <= KMC_IDLE;
      ctrl_command_byte_r <= kmc_pkg::CCB_RESET; // R10 R11 R12 R13 R14
      reply_pend_r        <= 1'b0;
      reply_r             <= 8'h00;
    end else begin
      if (load_reply) reply_pend_r <= 1'b0;
      case (cmd_state_r)
        KMC_IDLE: begin
          if (inbuf_full_r && !(wr_data || wr_cmd)) begin
            if (inbuf_is_cmd_r) cmd_state_r <= KMC_EXEC;
          end
        end
        KMC_EXEC: begin
          cmd_state_r <= KMC_IDLE;
          if (inbuf_r == kmc_pkg::CMD_READ_CCB) begin // R09
            reply_r      <= ctrl_command_byte_r;
            reply_pend_r <= 1'b1; // R16
          end else if (inbuf_r == kmc_pkg::CMD_WRITE_CCB) begin
            cmd_state_r <= KMC_WAIT_WR; // R09
          end
        end
        KMC_WAIT_WR: begin
          if (inbuf_full_r && !(wr_data || wr_cmd)) begin
            if (inbuf_is_cmd_r) begin
              cmd_state_r <= KMC_EXEC;
            end else begin
              ctrl_command_byte_r <= inbuf_r & kmc_pkg::CCB_WR_MASK; // R09
              cmd_state_r         <= KMC_IDLE;
            end
          end
        end
        default: cmd_state_r <= KMC_IDLE;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Output buffer
  // ----------------------------------------------------------------
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      outbuf_r            <= kmc_pkg::DATA_RESET; // R15
      outbuf_full_r       <= 1'b0;
      mouse_outbuf_full_r <= 1'b0;
      perr_r              <= 1'b0;
    end else if (load_reply) begin
      outbuf_r            <= reply_r; // R16
      outbuf_full_r       <= 1'b1; // R08
      mouse_outbuf_full_r <= 1'b0;
      perr_r              <= 1'b0;
    end else if (load_kbd) begin
      outbuf_r            <= xlate_on ? kbd_xlated : kbd_hold_r; // R16
      outbuf_full_r       <= 1'b1; // R08
      mouse_outbuf_full_r <= 1'b0;
      perr_r              <= kbd_hold_perr_r; // R01
    end else if (load_mouse) begin
      outbuf_r            <= mouse_hold_r;
      outbuf_full_r       <= 1'b1;
      mouse_outbuf_full_r <= 1'b1; // R04
      perr_r              <= mouse_hold_perr_r;
    end else if (rd_data) begin
      outbuf_full_r       <= 1'b0; // R17
      mouse_outbuf_full_r <= 1'b0; // R17
    end
  end

  // No link timeout is detected; bit kept for software compatibility
  always_ff @(posedge mclk) begin
    if (!rst_n) timeout_r <= 1'b0;
    else timeout_r <= 1'b0;
  end

  // ----------------------------------------------------------------
  // Status and read data
  // ----------------------------------------------------------------
  logic [7:0] status;
  always_comb begin
    status = kmc_pkg::STATUS_RESET;
    status[kmc_pkg::ST_PARITY]   = perr_r;
    status[kmc_pkg::ST_TIMEOUT]  = timeout_r;
    status[kmc_pkg::ST_MOUSE_OB] = mouse_outbuf_full_r; // R04
    status[kmc_pkg::ST_NOINHIB]  = ~kbd_inhibited; // R05
    status[kmc_pkg::ST_CMD_DATA] = inbuf_is_cmd_r; // R18
    status[kmc_pkg::ST_SYSFLAG]  =
      ctrl_command_byte_r[kmc_pkg::CB_SYSFLAG]; // R06 R13
    status[kmc_pkg::ST_IBF]      = inbuf_full_r; // R07
    status[kmc_pkg::ST_OBF]      = outbuf_full_r; // R08
  end

  // Registered read: data appears one cycle after the strobe
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      host_rdata <= 8'h00; // R03
    end else if (host_rd &&
                 host_addr == kmc_pkg::STATUS_PORT_ADDR) begin
      host_rdata <= status; // R03
    end else if (rd_data) begin
      host_rdata <= outbuf_r; // R15 R16
    end else begin
      host_rdata <= 8'h00;
    end
  end

  // ----------------------------------------------------------------
  // Interrupt lines and inhibit outputs
  // ----------------------------------------------------------------
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      kbd_irq_line    <= 1'b0;
      mouse_irq_line  <= 1'b0;
      kbd_inhibit_o   <= 1'b0;
      mouse_inhibit_o <= 1'b0;
    end else begin
      kbd_irq_line <= outbuf_full_r & ~mouse_outbuf_full_r &
                      ctrl_command_byte_r[kmc_pkg::CB_KBD_IE]; // R02 R14
      mouse_irq_line <= mouse_outbuf_full_r &
                        ctrl_command_byte_r[kmc_pkg::CB_MOUSE_IE]; // R02 R14
      kbd_inhibit_o   <= kbd_inhibited;
      mouse_inhibit_o <= mouse_inhibited;
    end
  end
endmodule

// File: tb/kmc_ps2_dev.sv
// Model of a serial keyboard or pointing device sending frames.
// Assumes: host never drives the lines back; lines have pull-ups.
module kmc_ps2_dev #(
  parameter int START_NS = 7
) (
  output logic link_clk,
  output logic link_rst_n,
  output logic link_data
);
  timeunit 1ns;
  timeprecision 1ns;

  initial begin
    link_clk   = 1'b1;
    link_data  = 1'b1;
    link_rst_n = 1'b0;
    #(START_NS);
    // Link reset is synchronous, so it needs some falling edges
    repeat (3) begin
      #15 link_clk = 1'b0;
      #15 link_clk = 1'b1;
    end
    link_rst_n = 1'b1;
  end

  // Start 0, data LSB first, odd parity, stop 1; clock idles high
  task automatic send(input logic [7:0] b, input logic bad_par);
    logic [10:0] f;
    f = {1'b1, (~^b) ^ bad_par, b, 1'b0};
    for (int i = 0; i < 11; i++) begin
      link_data = f[i];
      #15 link_clk = 1'b0;
      #15 link_clk = 1'b1;
    end
    // Released line floats back to its pull-up level
    link_data = 1'b1;
  endtask
endmodule

// File: tb/kmc_ctrl_chk.sv
// Checker of the controller host port, bound to kmc_ctrl.
// Assumes: all relations sampled on mclk with synchronous rst_n.
module kmc_ctrl_chk (
  input wire logic       mclk,
  input wire logic       rst_n,
  input wire logic [7:0] host_addr,
  input wire logic       host_wr,
  input wire logic       host_rd,
  input wire logic [7:0] host_rdata,
  input wire logic       kbd_irq_line,
  input wire logic       mouse_irq_line,
  input wire logic       kbd_inhibit_sw,
  input wire logic       mouse_inhibit_sw,
  input wire logic       kbd_inhibit_o,
  input wire logic       mouse_inhibit_o
);
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!rst_n);

  chk_rdata_quiet: assert property (
    !host_rd |=> host_rdata == 8'h00)
    else $error("read data not zero outside a read");
  chk_unmapped_zero: assert property (
    host_rd && host_addr != 8'h60 && host_addr != 8'h64
    |=> host_rdata == 8'h00)
    else $error("unmapped read returned data");
  chk_cmd_flags: assert property (
    host_wr && host_addr == 8'h64 ##1 host_rd && host_addr == 8'h64
    |=> host_rdata[3] && host_rdata[1])
    else $error("command write not flagged in status");
  chk_kbd_irq_clear: assert property (
    host_rd && host_addr == 8'h60 && kbd_irq_line |-> ##[1:3] !kbd_irq_line)
    else $error("keyboard interrupt not cleared by read");
  chk_ms_irq_clear: assert property (
    host_rd && host_addr == 8'h60 && mouse_irq_line
    |-> ##[1:3] !mouse_irq_line)
    else $error("mouse interrupt not cleared by read");
  chk_irq_exclusive: assert property (
    !(kbd_irq_line && mouse_irq_line))
    else $error("both interrupts high for one buffer");
  // Two sync stages plus the output register
  chk_kbd_inh_off: assert property (
    !kbd_inhibit_sw |-> ##3 !kbd_inhibit_o)
    else $error("keyboard inhibited without request");
  chk_ms_inh_off: assert property (
    !mouse_inhibit_sw |-> ##3 !mouse_inhibit_o)
    else $error("mouse inhibited without request");

  cov_kbd_irq: cover property ($rose(kbd_irq_line));
  cov_ms_irq: cover property ($rose(mouse_irq_line));
  cov_kbd_inh: cover property ($rose(kbd_inhibit_o));
endmodule

bind kmc_ctrl kmc_ctrl_chk i_kmc_ctrl_chk (
  .mclk(mclk), .rst_n(rst_n), .host_addr(host_addr),
  .host_wr(host_wr), .host_rd(host_rd), .host_rdata(host_rdata),
  .kbd_irq_line(kbd_irq_line), .mouse_irq_line(mouse_irq_line),
  .kbd_inhibit_sw(kbd_inhibit_sw), .mouse_inhibit_sw(mouse_inhibit_sw),
  .kbd_inhibit_o(kbd_inhibit_o), .mouse_inhibit_o(mouse_inhibit_o)
);

// File: tb/tb.sv
// Self-checking bench: host port tasks and two link device models.
// Assumes: status polling is the only completion signal.
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic       mclk, rst_n, host_wr, host_rd, kbd_inh, ms_inh;
  logic       kbd_clk, kbd_rst_n, kbd_data, ms_clk, ms_rst_n, ms_data;
  logic       kbd_irq, ms_irq, kbd_inh_o, ms_inh_o;
  logic [7:0] host_addr, host_wdata, host_rdata, v;
  int         fail_count = 0;
  int         checks_done = 0;
  time        wr_end = 0;
  time        rd_end = 0;

  kmc_ctrl i_kmc_ctrl (
    .mclk(mclk), .rst_n(rst_n), .kbd_clk(kbd_clk), .kbd_rst_n(kbd_rst_n),
    .kbd_data_i(kbd_data), .mouse_clk(ms_clk), .mouse_rst_n(ms_rst_n),
    .mouse_data_i(ms_data), .host_addr(host_addr),
    .host_wdata(host_wdata), .host_wr(host_wr), .host_rd(host_rd),
    .kbd_inhibit_sw(kbd_inh), .mouse_inhibit_sw(ms_inh),
    .host_rdata(host_rdata), .kbd_irq_line(kbd_irq),
    .mouse_irq_line(ms_irq), .kbd_inhibit_o(kbd_inh_o),
    .mouse_inhibit_o(ms_inh_o)
  );
  kmc_ps2_dev #(.START_NS(7)) i_kbd (.link_clk(kbd_clk),
    .link_rst_n(kbd_rst_n), .link_data(kbd_data));
  kmc_ps2_dev #(.START_NS(11)) i_ms (.link_clk(ms_clk),
    .link_rst_n(ms_rst_n), .link_data(ms_data));

  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end

  // ----------------------------------------------------------------
  // Shared tasks; each is entered 1 ns after a rising edge
  // ----------------------------------------------------------------
  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    checks_done++;
    if (got !== exp) begin
      fail_count++;
      $display("BAD %0t got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic summarize;
    $display("checks %0d mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  // Back-to-back strobes: let an edge pass so the strobe really drops
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    if (wr_end == $time) @(posedge mclk) #1;
    host_addr = a;
    host_wdata = d;
    host_wr = 1'b1;
    @(posedge mclk) #1;
    host_wr = 1'b0;
    wr_end = $time;
  endtask

  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    if (rd_end == $time) @(posedge mclk) #1;
    host_addr = a;
    host_rd = 1'b1;
    @(posedge mclk) #1;
    host_rd = 1'b0;
    rd_end = $time;
    d = host_rdata;
  endtask

  task automatic wait_st(input int b, input logic val);
    logic [7:0] s;
    for (int i = 0; i < 300; i++) begin
      rd(8'h64, s);
      if (s[b] === val) return;
    end
    fail_count++;
    $display("BAD %0t status wait ran out", $time);
    summarize();
  endtask

  task automatic set_ccb(input logic [7:0] d);
    wr(8'h64, 8'h60);
    wait_st(1, 1'b0);
    wr(8'h60, d);
    wait_st(1, 1'b0);
  endtask

  task automatic get_ccb(output logic [7:0] d);
    wr(8'h64, 8'h20);
    wait_st(0, 1'b1);
    rd(8'h60, d);
  endtask

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_reset;
    rd(8'h64, v);
    check(v, 8'h14);
    rd(8'h60, v);
    check(v, 8'h00);
    rd(8'h42, v);
    check(v, 8'h00);
    get_ccb(v);
    check(v, 8'h47);
  endtask

  task automatic t_ccb;
    wr(8'h64, 8'h60);
    rd(8'h64, v);
    check(v & 8'h0A, 8'h0A);
    wait_st(1, 1'b0);
    wr(8'h60, 8'hFF);
    rd(8'h64, v);
    check(v & 8'h0A, 8'h02);
    wait_st(1, 1'b0);
    get_ccb(v);
    check(v, 8'h77);
    set_ccb(8'h00);
    rd(8'h64, v);
    check(v & 8'h04, 8'h00);
    set_ccb(8'h04);
    rd(8'h64, v);
    check(v & 8'h04, 8'h04);
  endtask

  task automatic t_rx_irq;
    set_ccb(8'h07);
    i_kbd.send(8'hA5, 1'b0);
    wait_st(0, 1'b1);
    rd(8'h64, v);
    check(v & 8'h21, 8'h01);
    check({6'h00, kbd_irq, ms_irq}, 8'h02);
    rd(8'h60, v);
    check(v, 8'hA5);
    rd(8'h64, v);
    check(v & 8'h01, 8'h00);
    i_ms.send(8'h5A, 1'b0);
    wait_st(0, 1'b1);
    rd(8'h64, v);
    check(v & 8'h21, 8'h21);
    check({6'h00, kbd_irq, ms_irq}, 8'h01);
    rd(8'h60, v);
    check(v, 8'h5A);
    rd(8'h64, v);
    check(v & 8'h21, 8'h00);
  endtask

  task automatic t_irq_off;
    set_ccb(8'h04);
    i_kbd.send(8'h3C, 1'b0);
    i_ms.send(8'h77, 1'b0);
    wait_st(0, 1'b1);
    rd(8'h60, v);
    check(v, 8'h3C);
    check({6'h00, kbd_irq, ms_irq}, 8'h00);
    wait_st(0, 1'b1);
    rd(8'h64, v);
    check({v[5], 6'h00, ms_irq}, 8'h80);
    rd(8'h60, v);
    check(v, 8'h77);
  endtask

  task automatic t_inhibit;
    kbd_inh = 1'b1;
    ms_inh = 1'b1;
    rd(8'h64, v);
    rd(8'h64, v);
    check(v & 8'h10, 8'h00);
    check({6'h00, kbd_inh_o, ms_inh_o}, 8'h03);
    set_ccb(8'h14);
    rd(8'h64, v);
    check(v & 8'h10, 8'h10);
    check({6'h00, kbd_inh_o, ms_inh_o}, 8'h01);
    set_ccb(8'h34);
    check({6'h00, kbd_inh_o, ms_inh_o}, 8'h00);
    kbd_inh = 1'b0;
    ms_inh = 1'b0;
  endtask

  task automatic t_xlate_parity;
    set_ccb(8'h44);
    i_kbd.send(8'h1C, 1'b0);
    wait_st(0, 1'b1);
    rd(8'h60, v);
    check(v, 8'h1E);
    // Break prefix folds into the top bit of the next code
    i_kbd.send(8'hF0, 1'b0);
    i_kbd.send(8'h1C, 1'b0);
    wait_st(0, 1'b1);
    rd(8'h60, v);
    check(v, 8'h9E);
    set_ccb(8'h04);
    i_kbd.send(8'h11, 1'b1);
    wait_st(0, 1'b1);
    rd(8'h64, v);
    check(v & 8'h80, 8'h80);
    rd(8'h60, v);
    check(v, 8'h11);
  endtask

  initial begin
    rst_n = 1'b0;
    host_wr = 1'b0;
    host_rd = 1'b0;
    host_addr = 8'h00;
    host_wdata = 8'h00;
    kbd_inh = 1'b0;
    ms_inh = 1'b0;
    repeat (10) @(posedge mclk);
    #1 rst_n = 1'b1;
    @(posedge mclk) #1;
    t_reset();
    t_ccb();
    t_rx_irq();
    t_irq_off();
    t_inhibit();
    t_xlate_parity();
    summarize();
  end
endmodule
